// [inc/pssc_pkg.sv]
// shared constants for the pipelined sram sleep and cycle control
package pssc_pkg;

  // array shape: 512K words of two 9-bit bytes
  localparam int ADDR_W = 19;
  localparam int BYTES  = 2;
  localparam int BYTE_W = 9;

  // burst counter and burst order encodings
  localparam int         BURST_W           = 2;
  localparam logic [1:0] BURST_CNT_RST     = 2'h0;
  localparam logic [1:0] BURST_STEP        = 2'h1;
  localparam logic       BURST_LINEAR      = 1'h0;
  localparam logic       BURST_INTERLEAVED = 1'h1;

  // sleep entry and exit windows, two clock periods each
  localparam int CLK_PERIOD_NS      = 10;
  localparam int SLEEP_ENTRY_MAX_NS = 2 * CLK_PERIOD_NS;
  localparam int SLEEP_EXIT_MAX_NS  = 2 * CLK_PERIOD_NS;
  // longest times round down to whole cycles
  localparam int SLEEP_ENTRY_CYC    = SLEEP_ENTRY_MAX_NS / CLK_PERIOD_NS;
  localparam int SLEEP_EXIT_CYC     = SLEEP_EXIT_MAX_NS / CLK_PERIOD_NS;
  // synchroniser depth fits both windows
  localparam int SLEEP_SYNC_STAGES  = (SLEEP_ENTRY_CYC < SLEEP_EXIT_CYC) ?
                                      SLEEP_ENTRY_CYC : SLEEP_EXIT_CYC;

endpackage

// [rtl/pssc_mem_array.sv]
// storage array with byte-masked write port and registered read port
module pssc_mem_array #(
  parameter int AW     = 19,
  parameter int BYTES  = 2,
  parameter int BYTE_W = 9
) (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    we,
  input  wire logic [AW-1:0]           wAddr,
  input  wire logic [BYTES*BYTE_W-1:0] wData,
  input  wire logic [BYTES-1:0]        wBe,
  input  wire logic                    re,
  input  wire logic [AW-1:0]           rAddr,
  output logic      [BYTES*BYTE_W-1:0] rData
);

  logic [BYTES*BYTE_W-1:0] mem [0:(2**AW)-1];

  // byte-masked write
  always_ff @(posedge clk) begin
    if (we) begin
      for (int i = 0; i < BYTES; i++) begin
        if (wBe[i]) begin
          mem[wAddr][i*BYTE_W +: BYTE_W] <= wData[i*BYTE_W +: BYTE_W];
        end
      end
    end
  end

  // read data leave through a register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rData <= '0;
    end else if (re) begin
      rData <= mem[rAddr];
    end
  end

endmodule

// [rtl/pssc_sram_sleep.sv]
// pipelined no-gap sram core control with sleep entry and exit
// What this block does
// - sleep request high puts device asleep
// - asleep means deselected, held while request high
// - asleep ignores inputs, data outputs high-impedance
// - stop sampling within two clocks after rise
// - resume sampling within two clocks after fall
// - burst order linear when 0, interleaved when 1
// - selected only when all three selects agree
// - reads return newest data from write register
// - clock hold high stalls pipeline, no write
module pssc_sram_sleep #(
  parameter int ADDR_W = pssc_pkg::ADDR_W,
  parameter int BYTES  = pssc_pkg::BYTES,
  parameter int BYTE_W = pssc_pkg::BYTE_W
) (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    sleepRequest,
  input  wire logic                    chipSelectLow,
  input  wire logic                    secondSelectHigh,
  input  wire logic                    thirdSelectLow,
  input  wire logic                    advanceLoad,
  input  wire logic                    clockHoldLow,
  input  wire logic                    readNotWrite,
  input  wire logic [BYTES-1:0]        byteWriteLow,
  input  wire logic                    burstOrder,
  input  wire logic                    outputEnableLow,
  input  wire logic [ADDR_W-1:0]       addr,
  input  wire logic [BYTES*BYTE_W-1:0] dqIn,
  output logic      [BYTES*BYTE_W-1:0] dqOut,
  output logic                         dqOe,
  output logic                         asleep
);
  import pssc_pkg::*;

  localparam int DW = BYTES * BYTE_W;

  logic [SLEEP_SYNC_STAGES-1:0] sleepPipe_r;
  logic                         aValid_r, aWrite_r, bValid_r, bWrite_r;
  logic [ADDR_W-1:0]            aAddr_r, bAddr_r, wrAddr_r, burstBase_r;
  logic [BYTES-1:0]             aBw_r, bBw_r, wrBw_r, bypMask_r;
  logic [DW-1:0]                wrData_r, bypData_r, memRdata;
  logic                         wrPend_r, outValid_r;
  logic                         burstValid_r, burstWrite_r;
  logic [BURST_W-1:0]           burstCnt_r;

  // sleep request synchroniser, last stage is the sleep state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sleepPipe_r <= '0;
    end else begin
      sleepPipe_r <= {sleepPipe_r[SLEEP_SYNC_STAGES-2:0],
                      sleepRequest};
    end
  end
  // two stages give entry and exit in two edges, inside both windows
  assign asleep = sleepPipe_r[SLEEP_SYNC_STAGES-1];

  // cycle qualification
  wire selected = !chipSelectLow && !thirdSelectLow
                  && secondSelectHigh;
  wire adv      = !clockHoldLow && !asleep;
  wire load     = !advanceLoad;
  wire aValidNxt = load ? selected : burstValid_r;
  wire aWriteNxt = load ? !readNotWrite : burstWrite_r;

  // burst address generation on continue cycles
  wire [BURST_W-1:0] burstCntNxt = burstCnt_r + BURST_STEP;
  wire [BURST_W-1:0] burstLow = (burstOrder == BURST_INTERLEAVED) ?
      (burstBase_r[BURST_W-1:0] ^ burstCntNxt) :
      (burstBase_r[BURST_W-1:0] + burstCntNxt);
  wire [ADDR_W-1:0] contAddr = {burstBase_r[ADDR_W-1:BURST_W], burstLow};
  wire [ADDR_W-1:0] aAddrNxt = load ? addr : contAddr;

  // write data phase and array commit
  wire bWriting = bValid_r && bWrite_r;
  wire memWe    = adv && wrPend_r;
  wire memRe    = adv && aValid_r && !aWrite_r;

  // read-after-write bypass, newest write first
  wire hitNew  = bWriting && (bAddr_r == aAddr_r);
  wire hitHeld = wrPend_r && (wrAddr_r == aAddr_r);
  logic [DW-1:0]    bypData;
  logic [BYTES-1:0] bypMask;
  logic [DW-1:0]    readMerged;
  genvar g;
  generate
    for (g = 0; g < BYTES; g++) begin : gByte
      wire useNew  = hitNew && bBw_r[g];
      wire useHeld = hitHeld && wrBw_r[g];
      assign bypMask[g] = useNew || useHeld;
      assign bypData[g*BYTE_W +: BYTE_W] = useNew ?
          dqIn[g*BYTE_W +: BYTE_W] : wrData_r[g*BYTE_W +: BYTE_W];
      assign readMerged[g*BYTE_W +: BYTE_W] = bypMask_r[g] ?
          bypData_r[g*BYTE_W +: BYTE_W] : memRdata[g*BYTE_W +: BYTE_W];
    end
  endgenerate

  // address and control stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aValid_r <= 1'h0;
      aWrite_r <= 1'h0;
      aAddr_r  <= '0;
      aBw_r    <= '0;
    end else if (asleep) begin
      aValid_r <= 1'h0;
    end else if (adv) begin
      aValid_r <= aValidNxt;
      aWrite_r <= aWriteNxt;
      aAddr_r  <= aAddrNxt;
      aBw_r    <= ~byteWriteLow;
    end
  end

  // burst tracker
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      burstValid_r <= 1'h0;
      burstWrite_r <= 1'h0;
      burstBase_r  <= '0;
      burstCnt_r   <= BURST_CNT_RST;
    end else if (asleep) begin
      burstValid_r <= 1'h0;
    end else if (adv && load) begin
      burstValid_r <= selected;
      burstWrite_r <= !readNotWrite;
      burstBase_r  <= addr;
      burstCnt_r   <= BURST_CNT_RST;
    end else if (adv && burstValid_r) begin
      burstCnt_r <= burstCntNxt;
    end
  end

  // data phase stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bValid_r <= 1'h0;
      bWrite_r <= 1'h0;
      bAddr_r  <= '0;
      bBw_r    <= '0;
    end else if (asleep) begin
      bValid_r <= 1'h0;
    end else if (adv) begin
      bValid_r <= aValid_r;
      bWrite_r <= aWrite_r;
      bAddr_r  <= aAddr_r;
      bBw_r    <= aBw_r;
    end
  end

  // input data register, held until the array takes it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPend_r <= 1'h0;
      wrData_r <= '0;
      wrAddr_r <= '0;
      wrBw_r   <= '0;
    end else if (adv) begin
      wrPend_r <= bWriting;
      if (bWriting) begin
        wrData_r <= dqIn;
        wrAddr_r <= bAddr_r;
        wrBw_r   <= bBw_r;
      end
    end
  end

  // bypass capture beside the array read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bypData_r <= '0;
      bypMask_r <= '0;
    end else if (memRe) begin
      bypData_r <= bypData;
      bypMask_r <= bypMask;
    end
  end

  // registered read output
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      outValid_r <= 1'h0;
      dqOut      <= '0;
    end else if (asleep) begin
      outValid_r <= 1'h0;
    end else if (adv) begin
      outValid_r <= bValid_r && !bWrite_r;
      if (bValid_r && !bWrite_r) begin
        dqOut <= readMerged;
      end
    end
  end

  // drive only on a read result, never while asleep
  assign dqOe = outValid_r && !outputEnableLow && !asleep;

  pssc_mem_array #(
    .AW     (ADDR_W),
    .BYTES  (BYTES),
    .BYTE_W (BYTE_W)
  ) uArray (
    .clk    (clk),
    .resetn (resetn),
    .we     (memWe),
    .wAddr  (wrAddr_r),
    .wData  (wrData_r),
    .wBe    (wrBw_r),
    .re     (memRe),
    .rAddr  (aAddr_r),
    .rData  (memRdata)
  );

  // checks on sleep, stall, selection and linear burst stepping
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_sleep_entry: assert property (
    $rose(sleepRequest) ##1 sleepRequest |-> ##[0:1] asleep)
    else $error("sleep not entered within two clocks");
  a_sleep_exit: assert property (
    $fell(sleepRequest) ##1 !sleepRequest |-> ##[0:1] !asleep)
    else $error("sleep not left within two clocks");
  a_sleep_follows: assert property (
    sleepRequest [*3] |-> asleep)
    else $error("asleep not held while request high");
  a_sleep_hiz: assert property (
    asleep |=> !outValid_r && !dqOe)
    else $error("data outputs driven while asleep");
  a_sleep_ignores: assert property (
    asleep |=> !aValid_r && !bValid_r)
    else $error("cycle taken while asleep");
  a_wake_deselect: assert property (
    $fell(asleep) |-> !aValid_r && !bValid_r && !outValid_r && !dqOe)
    else $error("not deselected on leaving sleep");
  a_stall_nowrite: assert property (
    clockHoldLow && wrPend_r |-> !memWe ##1 wrPend_r && $stable(wrData_r))
    else $error("array written on a stall edge");
  a_stall_freeze: assert property (
    clockHoldLow && !asleep |=> $stable(dqOut) && $stable(bAddr_r)
      && $stable(aAddr_r))
    else $error("pipeline advanced on a stall edge");
  a_select_off: assert property (
    adv && !advanceLoad &&
    (chipSelectLow || thirdSelectLow || !secondSelectHigh) |=> !aValid_r)
    else $error("selected without all three selects");
  a_select_on: assert property (
    adv && !advanceLoad && !chipSelectLow && !thirdSelectLow
    && secondSelectHigh |=> aValid_r)
    else $error("not selected with all selects active");
  a_burst_linear: assert property (
    adv && advanceLoad && burstValid_r && burstOrder == BURST_LINEAR
    |=> aAddr_r[1:0] == $past(aAddr_r[1:0]) + 2'h1)
    else $error("linear burst address step wrong");

  c_sleep_cycle: cover property (
    $rose(asleep) ##[1:20] $fell(asleep));
  c_stall_read: cover property (clockHoldLow && bValid_r && !bWrite_r);
  c_burst_cont: cover property (adv && advanceLoad && burstValid_r);
  c_bypass_hit: cover property (memRe && (hitNew || hitHeld));

endmodule

// [verification/pssc_ctrl_model.sv]
// controller model: drives sram cycles and collects read words
module pssc_ctrl_model #(
  parameter int AW = 6,
  parameter int DW = 18
) (
  input  wire logic          clk,
  input  wire logic          clockHoldLow,
  input  wire logic [DW-1:0] dqOut,
  input  wire logic          dqOe,
  output logic      [2:0]    sel,
  output logic               advanceLoad,
  output logic               readNotWrite,
  output logic      [1:0]    byteWriteLow,
  output logic      [AW-1:0] addr,
  output logic      [DW-1:0] dqIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DW-1:0] dPipe [3];
  logic [2:0]    dDue;
  logic [DW-1:0] got [$];
  // idle bus at time zero: deselected load, no data due
  initial begin
    {sel, advanceLoad, readNotWrite, byteWriteLow} = 7'h57;
    addr = '0;
    dqIn = '0;
    dDue = '0;
  end
  // one cycle per call, entered just after a falling edge
  task automatic cyc(input logic [2:0] s, input logic l, input logic r,
                     input logic [AW-1:0] a, input logic [DW-1:0] d,
                     input logic [1:0] bw);
    sel = s;
    advanceLoad = l;
    readNotWrite = r;
    addr = a;
    byteWriteLow = bw;
    dPipe[2] = dPipe[1];
    dPipe[1] = dPipe[0];
    dPipe[0] = d;
    dDue = {dDue[1:0], !r};
    // write data trails its address by two cycles, else no stale value
    dqIn = dDue[2] ? dPipe[2] : ~dqIn;
    @(negedge clk);
  endtask
  // one word taken per advancing edge while the drive is enabled
  always @(posedge clk)
    if (!clockHoldLow && dqOe === 1'b1) got.push_back(dqOut);
endmodule

// [verification/tb_pssc_sram_sleep.sv]
// self-checking bench for the sram sleep and cycle control
module tb_pssc_sram_sleep;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] ON = 3'h2;
  logic clk = 0, resetn = 0, sleepRequest = 0, clockHoldLow = 0;
  logic burstOrder = 0, outputEnableLow = 0, dqOe, asleep;
  logic [2:0] sel;
  logic advanceLoad, readNotWrite;
  logic [1:0] byteWriteLow;
  logic [5:0] addr;
  logic [17:0] dqIn, dqOut;
  logic [17:0] mem [64];
  logic [17:0] exp [$];
  int errorCnt = 0, testsRun = 0;
  always #5 clk = ~clk;
  pssc_sram_sleep #(.ADDR_W(6)) u_dut (.clk(clk), .resetn(resetn),
    .sleepRequest(sleepRequest), .chipSelectLow(sel[2]),
    .secondSelectHigh(sel[1]), .thirdSelectLow(sel[0]),
    .advanceLoad(advanceLoad), .clockHoldLow(clockHoldLow),
    .readNotWrite(readNotWrite), .byteWriteLow(byteWriteLow),
    .burstOrder(burstOrder), .outputEnableLow(outputEnableLow),
    .addr(addr), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
    .asleep(asleep));
  pssc_ctrl_model #(.AW(6), .DW(18)) u_ctrl (.clk(clk),
    .clockHoldLow(clockHoldLow), .dqOut(dqOut), .dqOe(dqOe), .sel(sel),
    .advanceLoad(advanceLoad), .readNotWrite(readNotWrite),
    .byteWriteLow(byteWriteLow), .addr(addr), .dqIn(dqIn));
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    testsRun++;
    if (seen !== want) begin
      errorCnt++;
      $display("[FAIL] t=%0t seen=%0h want=%0h", $time, seen, want);
    end
  endtask
  // verdict and end of run
  task automatic completeRun();
    $display("checks=%0d errors=%0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // expected word after a byte-masked write
  function automatic logic [17:0] merge(logic [17:0] o, logic [17:0] n,
                                        logic [1:0] bw);
    return {bw[1] ? o[17:9] : n[17:9], bw[0] ? o[8:0] : n[8:0]};
  endfunction
  // expected burst address for step n
  function automatic logic [5:0] bAddr(logic [5:0] b, logic [1:0] n);
    return burstOrder ? {b[5:2], b[1:0] ^ n} : {b[5:2], b[1:0] + n};
  endfunction
  // selected writes update the reference at once, so reads see bypass
  task automatic wr(input logic [2:0] s, input logic [5:0] a,
                    input logic [17:0] d, input logic [1:0] bw);
    u_ctrl.cyc(s, 0, 0, a, d, bw);
    if (s == ON) mem[a] = merge(mem[a], d, bw);
  endtask
  task automatic rd(input logic [2:0] s, input logic [5:0] a);
    u_ctrl.cyc(s, 0, 1, a, 0, 3);
    if (s == ON) exp.push_back(mem[a]);
  endtask
  task automatic idle(input int n);
    repeat (n) u_ctrl.cyc(3'h5, 0, 1, 0, 0, 3);
  endtask
  task automatic hold(input int n);
    repeat (n) begin
      clockHoldLow = 1;
      @(negedge clk);
    end
    clockHoldLow = 0;
  endtask
  // drain the pipe, then match collected words against the reference
  task automatic flush();
    idle(4);
    check(u_ctrl.got.size(), exp.size());
    for (int i = 0; i < exp.size() && i < u_ctrl.got.size(); i++)
      check(u_ctrl.got[i], exp[i]);
    exp.delete();
    u_ctrl.got.delete();
  endtask
  // hang guard
  initial begin
    #200us;
    errorCnt++;
    completeRun();
  end
  initial begin
    logic [31:0] r;
    void'($urandom(32'h6d385f04));
    repeat (5) @(negedge clk);
    resetn = 1;
    for (int a = 0; a < 64; a++) wr(ON, a, $urandom, 0);
    // back-to-back write and read of one address, partial byte write
    wr(ON, 7, 18'h2A5A5, 0);
    rd(ON, 7);
    wr(ON, 7, 18'h15A5A, 2'h2);
    rd(ON, 7);
    flush();
    // random mix of reads, writes and select patterns
    repeat (80) begin
      r = $urandom;
      if (r[0]) rd(r[12] ? ON : r[3:1], r[9:4]);
      else wr(r[12] ? ON : r[3:1], r[9:4], r[31:14], r[11:10]);
    end
    flush();
    // burst write then burst read of the same four words, both orders
    for (int m = 0; m < 4; m++) begin
      burstOrder = m[1];
      r = $urandom;
      if (m[0]) rd(ON, 6'h0D);
      else wr(ON, 6'h0D, r[17:0], 0);
      for (int n = 1; n < 4; n++) begin
        u_ctrl.cyc(ON, 1, m[0], 0, {r[17:2], n[1:0]}, 0);
        if (m[0]) exp.push_back(mem[bAddr(6'h0D, n[1:0])]);
        else mem[bAddr(6'h0D, n[1:0])] = {r[17:2], n[1:0]};
      end
    end
    flush();
    // stalls must not repeat or advance cycles
    wr(ON, 3, 18'h3C3C3, 0);
    hold(2);
    rd(ON, 3);
    hold(3);
    rd(ON, 3);
    hold(2);
    flush();
    // output enable held off: the read result must not be driven
    outputEnableLow = 1;
    u_ctrl.cyc(ON, 0, 1, 5, 0, 3);
    idle(3);
    outputEnableLow = 0;
    flush();
    // sleep entry, ignored traffic, exit
    idle(2);
    sleepRequest = 1;
    idle(1);
    check(asleep, 0);
    idle(1);
    check(asleep, 1);
    repeat (2) begin
      u_ctrl.cyc(ON, 0, 0, 9, ~mem[9], 0);
      u_ctrl.cyc(ON, 0, 1, 9, 0, 3);
      check(dqOe, 0);
    end
    check(asleep, 1);
    sleepRequest = 0;
    idle(1);
    check(asleep, 1);
    idle(1);
    check(asleep, 0);
    check(dqOe, 0);
    rd(ON, 9);
    flush();
    completeRun();
  end
endmodule
